/* verilog/tvd_dispatch.sv */
// Behaviour
// [RULE_01] Every interrupt node has its own request flag, enable flag, trap number and vector.
// [RULE_02] The two-wire serial unit has a data node at trap 40h and a protocol node at trap 41h.
// [RULE_03] A hardware trap is non-maskable and branches to its own vector like an interrupt does.
// [RULE_04] Each hardware trap cause sets its own bit in the trap flag register.
// [RULE_05] A hardware trap preempts anything except a trap service of higher priority. The code also holds it off during a service of its own class.
// [RULE_06] While a hardware trap service runs, standard interrupts are not dispatched.
// [RULE_07] Hardware reset, software reset and watchdog overflow go to vector 0, trap 0, setting no flag.
// [RULE_08] Non-maskable interrupt, stack overflow and underflow use traps 02h, 04h and 06h.
// [RULE_09] All class B traps share vector 28h while each sets its own flag.
// [RULE_10] A software trap takes any number 00h to 7Fh and runs at the current CPU priority.
// [RULE_11] Software may set a node request flag and the node then requests like a peripheral.
// [RULE_12] Each node has one of sixteen levels and only a higher level interrupts a service.
// [RULE_13] The vector is four times the trap number and reserved numbers 0Bh to 0Fh have no source.
`timescale 1ns/1ns
`include "tvd_defs.svh"

module tvd_dispatch
	import tvd_pkg::*;
#(
	parameter int N  = `TVD_NODES,
	parameter int IW = $clog2(N)
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [N-1:0] periph_req,
	input  tvd_cause_t       cpu_exc,
	input  wire logic        sw_reset,
	input  wire logic        wdt_overflow,
	input  wire logic        sw_trap_req,
	input  wire logic [6:0]  sw_trap_num,
	input  wire logic [3:0]  cpu_prio,
	input  tvd_class_t       cpu_trap_class,
	input  wire logic        disp_ack,
	output tvd_disp_t        disp,
	output logic             disp_valid,
	output logic             trap_irq
);

	// ----------------------------------------
	// Functions
	// ----------------------------------------
	function automatic logic [15:0] vec_of(input logic [6:0] num);
		vec_of = {7'h00, num, 2'b00}; // [RULE_13]
	endfunction

	function automatic tvd_reg_t decode(input logic [11:0] a);
		decode = TVD_REG_NONE;
		if (a[1:0] == 2'b00) begin
			if (a == `TVD_OFF_TFR) begin
				decode = TVD_REG_TFR;
			end else if (a == `TVD_OFF_MASK) begin
				decode = TVD_REG_MASK;
			end else if (a == `TVD_OFF_STAT) begin
				decode = TVD_REG_STAT;
			end else if (a[11:8] == `TVD_NODE_PAGE && int'(a[7:2]) < N) begin
				decode = TVD_REG_NODE;
			end
		end
	endfunction

	function automatic tvd_disp_t mk(input logic [6:0] num, input logic [3:0] prio, input tvd_class_t c);
		mk.trap_num = num;
		mk.vector   = vec_of(num);
		mk.prio     = prio;
		mk.tclass   = c;
	endfunction

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic [N-1:0]   req_q;
	logic [N-1:0]   en_q;
	logic [4*N-1:0] lvl_q;
	logic [7:0]     flags_q;
	logic [7:0]     pend_q;
	logic [7:0]     mask_q;
	logic [7:0]     mask_d;
	logic [7:0]     w1c;
	logic [7:0]     clr_pend;
	logic           acc_clr;
	logic [IW-1:0]  acc_idx;
	logic           node_wr;
	tvd_reg_t       dec;
	logic           acc;
	logic           done;
	logic           wr;
	logic           pready_d;
	logic           pslverr_d;
	logic [31:0]    prdata_d;
	logic [31:0]    rd_val;
	logic [IW-1:0]  rd_idx;
	logic           irq_d;
	tvd_state_t     state_q;
	tvd_state_t     state_d;
	tvd_disp_t      disp_d;
	logic           disp_valid_d;
	logic           boot_q;
	logic           boot_d;
	logic           rst_pend_q;
	logic           rst_pend_d;
	logic           sw_pend_q;
	logic           sw_pend_d;
	logic [6:0]     sw_num_q;
	logic [6:0]     sw_num_d;
	logic           sel_valid;
	tvd_disp_t      sel;
	logic           sel_boot;
	logic           sel_sw;
	logic           best_hit;
	logic [IW-1:0]  best_idx;
	logic [3:0]     best_lvl;

	// ----------------------------------------
	// Node and trap flag stores
	// ----------------------------------------
	tvd_node_bank #(.N(N), .IW(IW)) u_nodes (
		.pclk       (pclk),
		.presetn    (presetn),
		.periph_req (periph_req),
		.sw_wr      (node_wr),
		.sw_idx     (paddr[IW+1:2]),
		.sw_req     (pwdata[`TVD_NODE_REQ_BIT]),
		.sw_en      (pwdata[`TVD_NODE_EN_BIT]),
		.sw_lvl     (pwdata[`TVD_NODE_LVL_LSB +: 4]),
		.acc_clr    (acc_clr),
		.acc_idx    (acc_idx),
		.req_q      (req_q),
		.en_q       (en_q),
		.lvl_q      (lvl_q)
	);

	tvd_trap_flags u_flags (
		.pclk     (pclk),
		.presetn  (presetn),
		.cause    (cpu_exc),
		.w1c      (w1c),
		.clr_pend (clr_pend),
		.flags_q  (flags_q),
		.pend_q   (pend_q)
	);

	// ----------------------------------------
	// APB slave
	// ----------------------------------------
	always_comb begin
		dec       = decode(paddr);
		acc       = psel && penable;
		pready_d  = acc && !pready;
		done      = acc && pready;
		wr        = done && pwrite;
		w1c       = (wr && dec == TVD_REG_TFR) ? pwdata[7:0] : 8'h00;
		node_wr   = wr && dec == TVD_REG_NODE;
		mask_d    = (wr && dec == TVD_REG_MASK) ? pwdata[7:0] : mask_q;
		rd_idx    = paddr[IW+1:2];
		case (dec)
			TVD_REG_TFR: rd_val = {24'h000000, flags_q};
			TVD_REG_MASK: rd_val = {24'h000000, mask_q};
			TVD_REG_STAT: rd_val = {17'h00000, disp.trap_num, 6'h00, disp_valid, boot_q};
			TVD_REG_NODE: rd_val = {26'h0000000, lvl_q[4*rd_idx +: 4], en_q[rd_idx], req_q[rd_idx]};
			default: rd_val = 32'h00000000;
		endcase
		prdata_d  = (pready_d && !pwrite) ? rd_val : prdata;
		pslverr_d = pready_d && dec == TVD_REG_NONE;
		irq_d     = |(flags_q & mask_q);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata   <= 32'h00000000;
			pready   <= 1'b0;
			pslverr  <= 1'b0;
			mask_q   <= `TVD_MASK_RST;
			trap_irq <= 1'b0;
		end else begin
			prdata   <= prdata_d;
			pready   <= pready_d;
			pslverr  <= pslverr_d;
			mask_q   <= mask_d;
			trap_irq <= irq_d;
		end
	end

	// ----------------------------------------
	// Source selection
	// ----------------------------------------
	always_comb begin
		best_hit = 1'b0;
		best_idx = '0;
		best_lvl = cpu_prio;
		// Strictly above the running level; lowest node wins a tie
		for (int k = 0; k < N; k++) begin
			if (req_q[k] && en_q[k] && lvl_q[4*k +: 4] > best_lvl) begin
				best_hit = 1'b1; // [RULE_12]
				best_idx = IW'(k);
				best_lvl = lvl_q[4*k +: 4];
			end
		end
		sel_valid = 1'b1;
		sel_boot  = 1'b0;
		sel_sw    = 1'b0;
		clr_pend  = 8'h00;
		acc_clr   = 1'b0;
		acc_idx   = best_idx;
		sel       = mk(`TVD_TRAP_RESET, `TVD_HW_PRIO, TVD_CLS_A);
		if (boot_q || rst_pend_q) begin
			sel_boot = 1'b1; // [RULE_07]
		end else if (pend_q[`TVD_TFR_NMI] && cpu_trap_class < TVD_CLS_A) begin
			sel      = mk(`TVD_TRAP_NMI, `TVD_HW_PRIO, TVD_CLS_A); // [RULE_08]
			clr_pend = 8'h01 << `TVD_TFR_NMI; // [RULE_05]
		end else if (pend_q[`TVD_TFR_STKOV] && cpu_trap_class < TVD_CLS_A) begin
			sel      = mk(`TVD_TRAP_STKOV, `TVD_HW_PRIO, TVD_CLS_A); // [RULE_08]
			clr_pend = 8'h01 << `TVD_TFR_STKOV;
		end else if (pend_q[`TVD_TFR_STKUN] && cpu_trap_class < TVD_CLS_A) begin
			sel      = mk(`TVD_TRAP_STKUN, `TVD_HW_PRIO, TVD_CLS_A); // [RULE_08]
			clr_pend = 8'h01 << `TVD_TFR_STKUN;
		end else if (|(pend_q & `TVD_CLASSB_MASK) && cpu_trap_class < TVD_CLS_B) begin
			sel      = mk(`TVD_TRAP_CLASSB, `TVD_HW_PRIO, TVD_CLS_B); // [RULE_09]
			clr_pend = `TVD_CLASSB_MASK;
		end else if (sw_pend_q) begin
			sel    = mk(sw_num_q, cpu_prio, cpu_trap_class); // [RULE_10]
			sel_sw = 1'b1;
		end else if (best_hit && cpu_trap_class == TVD_CLS_NONE) begin
			// Node index maps to trap numbers 10h upward, e.g. 40h/41h for the two-wire unit
			sel     = mk(`TVD_TRAP_NODE0 + 7'(best_idx), best_lvl, TVD_CLS_NONE); // [RULE_06] [RULE_02]
			acc_clr = state_q == TVD_ST_IDLE; // [RULE_01]
		end else begin
			sel_valid = 1'b0;
		end
		if (state_q != TVD_ST_IDLE) begin
			clr_pend = 8'h00;
		end
	end

	// ----------------------------------------
	// Dispatch offer to the sequencer
	// ----------------------------------------
	always_comb begin
		state_d      = state_q;
		disp_d       = disp;
		disp_valid_d = disp_valid;
		boot_d       = boot_q;
		rst_pend_d   = rst_pend_q;
		sw_pend_d    = sw_pend_q;
		sw_num_d     = sw_num_q;
		case (state_q)
			TVD_ST_IDLE: begin
				if (sel_valid) begin
					state_d      = TVD_ST_OFFER; // [RULE_03]
					disp_d       = sel;
					disp_valid_d = 1'b1;
					if (sel_boot) begin
						boot_d     = 1'b0;
						rst_pend_d = 1'b0;
					end
					if (sel_sw) begin
						sw_pend_d = 1'b0;
					end
				end
			end
			TVD_ST_OFFER: begin
				if (disp_ack) begin
					state_d      = TVD_ST_IDLE;
					disp_valid_d = 1'b0;
				end
			end
			default: begin
				state_d      = TVD_ST_IDLE;
				disp_valid_d = 1'b0;
			end
		endcase
		// New requests win over the claim in the same cycle
		if (sw_reset || wdt_overflow) begin
			rst_pend_d = 1'b1; // [RULE_07]
		end
		if (sw_trap_req) begin
			sw_pend_d = 1'b1; // [RULE_10]
			sw_num_d  = sw_trap_num;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q    <= TVD_ST_IDLE;
			disp       <= '0;
			disp_valid <= 1'b0;
			boot_q     <= 1'b1;
			rst_pend_q <= 1'b0;
			sw_pend_q  <= 1'b0;
			sw_num_q   <= 7'h00;
		end else begin
			state_q    <= state_d;
			disp       <= disp_d;
			disp_valid <= disp_valid_d;
			boot_q     <= boot_d;
			rst_pend_q <= rst_pend_d;
			sw_pend_q  <= sw_pend_d;
			sw_num_q   <= sw_num_d;
		end
	end

endmodule

/* verilog/tvd_defs.svh */
`ifndef TVD_DEFS_SVH
`define TVD_DEFS_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define TVD_OFF_TFR       12'h000
`define TVD_OFF_MASK      12'h004
`define TVD_OFF_STAT      12'h008
`define TVD_OFF_NODE      12'h100
`define TVD_NODE_PAGE     4'h1

// ----------------------------------------
// Field positions
// ----------------------------------------
`define TVD_NODE_REQ_BIT  0
`define TVD_NODE_EN_BIT   1
`define TVD_NODE_LVL_LSB  2
`define TVD_STAT_BOOT_BIT 0
`define TVD_STAT_VAL_BIT  1
`define TVD_STAT_NUM_LSB  8
`define TVD_TFR_NMI       0
`define TVD_TFR_STKOV     1
`define TVD_TFR_STKUN     2
`define TVD_TFR_B_LSB     3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define TVD_TFR_RST       8'h00
`define TVD_MASK_RST      8'h00
`define TVD_NODE_LVL_RST  4'h0

// ----------------------------------------
// Trap numbers and counts
// ----------------------------------------
`define TVD_TRAP_RESET    7'h00
`define TVD_TRAP_NMI      7'h02
`define TVD_TRAP_STKOV    7'h04
`define TVD_TRAP_STKUN    7'h06
`define TVD_TRAP_CLASSB   7'h0a
`define TVD_TRAP_NODE0    7'h10
`define TVD_NODES         60
`define TVD_HW_PRIO       4'hf
`define TVD_CLASSB_MASK   8'hf8

`endif

/* verilog/tvd_pkg.sv */
package tvd_pkg;

	// Hardware trap causes, bit 7 first
	typedef struct packed {
		logic bad_external_bus;
		logic bad_instr_fetch;
		logic bad_word_operand;
		logic protected_instr_fault;
		logic bad_opcode;
		logic stack_under;
		logic stack_over;
		logic nmi;
	} tvd_cause_t;

	typedef enum logic [1:0] {
		TVD_CLS_NONE,
		TVD_CLS_B,
		TVD_CLS_A
	} tvd_class_t;

	typedef struct packed {
		logic [6:0]  trap_num;
		logic [15:0] vector;
		logic [3:0]  prio;
		tvd_class_t  tclass;
	} tvd_disp_t;

	typedef enum logic [2:0] {
		TVD_REG_TFR,
		TVD_REG_MASK,
		TVD_REG_STAT,
		TVD_REG_NODE,
		TVD_REG_NONE
	} tvd_reg_t;

	typedef enum {
		TVD_ST_IDLE,
		TVD_ST_OFFER
	} tvd_state_t;

endpackage

/* verilog/tvd_node_bank.sv */
`timescale 1ns/1ns
`include "tvd_defs.svh"

module tvd_node_bank
	import tvd_pkg::*;
#(
	parameter int N  = `TVD_NODES,
	parameter int IW = $clog2(N)
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic [N-1:0]      periph_req,
	input  wire logic              sw_wr,
	input  wire logic [IW-1:0]     sw_idx,
	input  wire logic              sw_req,
	input  wire logic              sw_en,
	input  wire logic [3:0]        sw_lvl,
	input  wire logic              acc_clr,
	input  wire logic [IW-1:0]     acc_idx,
	output logic      [N-1:0]      req_q,
	output logic      [N-1:0]      en_q,
	output logic      [4*N-1:0]    lvl_q
);

	// ----------------------------------------
	// One request, enable and level per node
	// ----------------------------------------
	genvar i;
	generate
		for (i = 0; i < N; i++) begin : g_node
			logic       req_d;
			logic       en_d;
			logic [3:0] lvl_d;
			logic       hit_sw;
			logic       hit_acc;

			always_comb begin
				hit_sw  = sw_wr && (sw_idx == IW'(i));
				hit_acc = acc_clr && (acc_idx == IW'(i));
				req_d   = req_q[i];
				en_d    = en_q[i];
				lvl_d   = lvl_q[4*i +: 4];
				if (hit_sw) begin
					req_d = sw_req; // [RULE_11]
					en_d  = sw_en;
					lvl_d = sw_lvl; // [RULE_12]
				end else if (hit_acc) begin
					req_d = 1'b0;
				end
				// Peripheral event wins over any clear in the same cycle
				if (periph_req[i]) begin
					req_d = 1'b1; // [RULE_01]
				end
			end

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					req_q[i]        <= 1'b0;
					en_q[i]         <= 1'b0;
					lvl_q[4*i +: 4] <= `TVD_NODE_LVL_RST;
				end else begin
					req_q[i]        <= req_d;
					en_q[i]         <= en_d;
					lvl_q[4*i +: 4] <= lvl_d;
				end
			end
		end
	endgenerate

endmodule

/* verilog/tvd_trap_flags.sv */
`timescale 1ns/1ns
`include "tvd_defs.svh"

module tvd_trap_flags
	import tvd_pkg::*;
(
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  tvd_cause_t      cause,
	input  wire logic [7:0] w1c,
	input  wire logic [7:0] clr_pend,
	output logic      [7:0] flags_q,
	output logic      [7:0] pend_q
);

	logic [7:0] flags_d;
	logic [7:0] pend_d;

	// ----------------------------------------
	// Sticky flags and dispatch-pending bits
	// ----------------------------------------
	always_comb begin
		// A new cause beats a clear in the same cycle
		flags_d = (flags_q & ~w1c) | cause; // [RULE_04]
		pend_d  = (pend_q & ~clr_pend) | cause; // [RULE_03]
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags_q <= `TVD_TFR_RST;
			pend_q  <= 8'h00;
		end else begin
			flags_q <= flags_d;
			pend_q  <= pend_d;
		end
	end

endmodule

/* verification/tvd_props.sv */
`timescale 1ns/1ns
module tvd_props
	import tvd_pkg::*;
#(
	parameter int N = 60
) (
	input wire logic         pclk,
	input wire logic         presetn,
	input wire logic         psel,
	input wire logic         penable,
	input wire logic         pwrite,
	input wire logic [11:0]  paddr,
	input wire logic [31:0]  pwdata,
	input wire logic [31:0]  prdata,
	input wire logic         pready,
	input wire logic         pslverr,
	input wire logic [N-1:0] periph_req,
	input tvd_cause_t        cpu_exc,
	input wire logic         sw_reset,
	input wire logic         wdt_overflow,
	input wire logic         sw_trap_req,
	input wire logic [6:0]   sw_trap_num,
	input wire logic [3:0]   cpu_prio,
	input tvd_class_t        cpu_trap_class,
	input wire logic         disp_ack,
	input tvd_disp_t         disp,
	input wire logic         disp_valid,
	input wire logic         trap_irq
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// ----------------------------------------
	// Offer of a given trap number
	// ----------------------------------------
	sequence s_offer(logic [6:0] t);
		disp_valid && disp.trap_num == t;
	endsequence

	pready_once_a: assert property (pready |=> !pready) else $error("pready held over one cycle");
	pready_wait_a: assert property (psel && penable && !pready |=> pready) else $error("pready not in second access cycle");
	slverr_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
	vector_x4_a: assert property (disp_valid |-> disp.vector == {7'h00, disp.trap_num, 2'b00})
		else $error("vector not four times trap");
	offer_hold_a: assert property (disp_valid && !disp_ack |=> disp_valid && $stable(disp))
		else $error("offer dropped or changed");
	ack_release_a: assert property (disp_valid && disp_ack |=> !disp_valid) else $error("offer kept after ack");
	classb_vec_a: assert property (disp_valid && disp.tclass == TVD_CLS_B |-> s_offer(7'h0a)
		and disp.vector == 16'h0028) else $error("class b offer wrong");
	nmi_vec_a: assert property (cpu_exc.nmi && !disp_valid && cpu_trap_class == TVD_CLS_NONE
		&& !sw_reset && !wdt_overflow |-> ##2 s_offer(7'h02)) else $error("nmi not offered");
	reset_vec_a: assert property ((sw_reset || wdt_overflow) && !disp_valid |-> ##2 s_offer(7'h00))
		else $error("reset vector missing");
	sw_trap_a: assert property (sw_trap_req && !disp_valid && cpu_trap_class == TVD_CLS_NONE
		&& cpu_exc == '0 && !sw_reset && !wdt_overflow |-> ##2 (disp_valid && disp.trap_num == $past(sw_trap_num, 2)
		&& disp.prio == $past(cpu_prio, 2))) else $error("software trap offer wrong");
endmodule

/* verification/tvd_seq_model.sv */
`timescale 1ns/1ns
module tvd_seq_model
	import tvd_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input tvd_disp_t disp,
	input wire logic disp_valid,
	input wire logic stall,
	output logic     disp_ack,
	output tvd_disp_t taken,
	output int       taken_cnt
);
	// Takes each offer one cycle after it appears unless stalled
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			disp_ack <= 1'b0;
			taken <= '0;
			taken_cnt <= 0;
		end else begin
			disp_ack <= disp_valid && !disp_ack && !stall;
			if (disp_valid && disp_ack) begin
				taken <= disp;
				taken_cnt <= taken_cnt + 1;
			end
		end
	end
endmodule

/* verification/testbench.sv */
`timescale 1ns/1ns
module testbench;
	import tvd_pkg::*;
	localparam int N = 60;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic sw_reset, wdt_overflow, sw_trap_req, disp_ack, disp_valid, trap_irq, stall;
	logic [11:0]  paddr;
	logic [31:0]  pwdata, prdata, rd;
	logic [N-1:0] periph_req;
	logic [6:0]   sw_trap_num;
	logic [3:0]   cpu_prio;
	tvd_cause_t   cpu_exc;
	tvd_class_t   cpu_trap_class;
	tvd_disp_t    disp, taken;
	int           taken_cnt, seen, n_fail, samples_checked;

	tvd_dispatch #(.N(N)) uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.periph_req, .cpu_exc, .sw_reset, .wdt_overflow, .sw_trap_req, .sw_trap_num, .cpu_prio, .cpu_trap_class,
		.disp_ack, .disp, .disp_valid, .trap_irq);
	tvd_seq_model seq (.pclk, .presetn, .disp, .disp_valid, .stall, .disp_ack, .taken, .taken_cnt);

	initial pclk = 1'b0;
	always #5 pclk = ~pclk;

	task check(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (k >= 20) n_fail++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task rdc(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(rd, exp);
	endtask

	task take(input logic [6:0] t, input logic [15:0] v);
		int k;
		k = 0;
		while (taken_cnt == seen && k < 40) begin
			@(posedge pclk);
			k++;
		end
		seen = taken_cnt;
		check(taken.trap_num, t);
		check(taken.vector, v);
	endtask

	task pulse(input tvd_cause_t c);
		cpu_exc <= c;
		@(posedge pclk);
		cpu_exc <= '0;
		@(posedge pclk);
	endtask

	task quiet;
		repeat (6) @(posedge pclk);
		check(disp_valid, 1'b0);
	endtask

	task complete_run;
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial begin
		#300000;
		n_fail++;
		complete_run;
	end

	initial begin
		{presetn, psel, penable, pwrite, sw_reset, wdt_overflow, sw_trap_req, stall} = '0;
		{paddr, pwdata, periph_req, sw_trap_num, cpu_prio, cpu_exc} = '0;
		cpu_trap_class = TVD_CLS_NONE;
		{seen, n_fail, samples_checked} = '0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		take(7'h00, 16'h0000);
		rdc(12'h000, 32'h0);
		rdc(12'h004, 32'h0);
		wr_mask: apb(1'b1, 12'h004, 32'hff);
		rdc(12'h004, 32'hff);
		apb(1'b0, 12'h00c, 32'h0);
		check(err, 1'b1);
		$display("test registers done");
		for (int i = 0; i < 8; i++) begin
			pulse(tvd_cause_t'(8'h01 << i));
			take(7'(i < 3 ? 2 + 2 * i : 10), 16'(i < 3 ? 8 + 8 * i : 40));
			rdc(12'h000, 32'h1 << i);
			check(trap_irq, 1'b1);
			apb(1'b1, 12'h000, 32'h1 << i);
			rdc(12'h000, 32'h0);
			check(trap_irq, 1'b0);
		end
		apb(1'b1, 12'h004, 32'h0);
		pulse(tvd_cause_t'(8'h01));
		take(7'h02, 16'h0008);
		check(trap_irq, 1'b0);
		apb(1'b1, 12'h000, 32'hff);
		$display("test hardware traps done");
		cpu_trap_class <= TVD_CLS_A;
		pulse(tvd_cause_t'(8'h09));
		quiet;
		cpu_trap_class <= TVD_CLS_B;
		take(7'h02, 16'h0008);
		quiet;
		cpu_trap_class <= TVD_CLS_NONE;
		take(7'h0a, 16'h0028);
		apb(1'b1, 12'h000, 32'hff);
		$display("test preemption done");
		sw_reset <= 1'b1;
		@(posedge pclk);
		sw_reset <= 1'b0;
		take(7'h00, 16'h0000);
		wdt_overflow <= 1'b1;
		@(posedge pclk);
		wdt_overflow <= 1'b0;
		take(7'h00, 16'h0000);
		rdc(12'h000, 32'h0);
		cpu_prio <= 4'h3;
		for (int b = 0; b < 7; b++) begin
			sw_trap_num <= 7'h7f >> b;
			sw_trap_req <= 1'b1;
			@(posedge pclk);
			sw_trap_req <= 1'b0;
			take(7'h7f >> b, 16'({7'h7f >> b, 2'b00}));
			check(taken.prio, 4'h3);
		end
		cpu_prio <= 4'h0;
		$display("test reset and software traps done");
		for (int n = 48; n < 54; n++) begin
			apb(1'b1, 12'(256 + 4 * n), 32'h16);
			periph_req[n] <= 1'b1;
			@(posedge pclk);
			periph_req <= '0;
			take(7'(16 + n), 16'(64 + 4 * n));
		end
		apb(1'b1, 12'h1bc, 32'h17);
		take(7'h3f, 16'h00fc);
		cpu_prio <= 4'h5;
		periph_req[48] <= 1'b1;
		@(posedge pclk);
		periph_req <= '0;
		quiet;
		rdc(12'h1c0, 32'h17);
		cpu_prio <= 4'h4;
		cpu_trap_class <= TVD_CLS_B;
		quiet;
		cpu_trap_class <= TVD_CLS_NONE;
		stall <= 1'b1;
		repeat (6) @(posedge pclk);
		check(disp_valid, 1'b1);
		rdc(12'h008, 32'h00004002);
		stall <= 1'b0;
		take(7'h40, 16'h0100);
		$display("test nodes done");
		complete_run;
	end
endmodule

bind tvd_dispatch tvd_props #(.N(N)) chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
	.pslverr, .periph_req, .cpu_exc, .sw_reset, .wdt_overflow, .sw_trap_req, .sw_trap_num, .cpu_prio, .cpu_trap_class,
	.disp_ack, .disp, .disp_valid, .trap_irq);
